/* core/serial_path_test.sv */
// Self-test sequencer for the serial video data paths, with its registers.
module serial_path_test
   import selftest_pkg::*;
(
   // Clock and reset.
   input  wire logic          CLK,
   input  wire logic          RSTN,
   // Front-end status.
   input  wire logic          SIG_A,
   input  wire logic          LOCK_A,
   input  wire logic          SIG_B,
   input  wire logic          LOCK_B,
   input  wire logic          SYNC_ERR_A,
   input  wire logic          SYNC_ERR_B,
   // Deserialized words.
   input  wire logic [DW-1:0] DATA_A,
   input  wire logic [DW-1:0] DATA_B,
   input  wire logic [DW-1:0] DATA_C,
   // Toward acquisition.
   output logic [DW-1:0]      VIDEO_OUT,
   output logic [1:0]         ACQ_MODE,
   output logic               IRQ,
   // AXI4-Lite write address and data.
   input  wire logic [7:0]    AWADDR,
   input  wire logic          AWVALID,
   output logic               AWREADY,
   input  wire logic [31:0]   WDATA,
   input  wire logic [3:0]    WSTRB,
   input  wire logic          WVALID,
   output logic               WREADY,
   // AXI4-Lite write response.
   output logic [1:0]         BRESP,
   output logic               BVALID,
   input  wire logic          BREADY,
   // AXI4-Lite read.
   input  wire logic [7:0]    ARADDR,
   input  wire logic          ARVALID,
   output logic               ARREADY,
   output logic [31:0]        RDATA,
   output logic [1:0]         RRESP,
   output logic               RVALID,
   input  wire logic          RREADY
);

   // -------------------------------------------------------------------
   // Declarations.
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE, S_LOCK, S_SYNC, S_ROUTE, S_CAPTURE, S_NEXT, S_DONE
   } state_t;

   state_t        state;            // Sequencer state.
   logic [1:0]    phase;            // 0 A, 1 B, 2 eye, 3 jitter.
   logic [3:0]    settle;           // Route settling counter.
   outcome_t      res [NCHK];       // Held check outcomes.
   logic [DW-1:0] stuck_lo [NPATH]; // Bits only ever low.
   logic [DW-1:0] stuck_hi [NPATH]; // Bits only ever high.
   logic          busy;             // A run is in progress.
   logic          done;             // A run has completed.
   logic          any_fail;         // Some check failed in this run.
   logic          sel_b_sw;         // Normal routing choice.
   acq_t          mode_sw;          // Normal acquisition mode.
   logic [15:0]   reclen;           // Capture record length.
   logic [1:0]    irq_stat;         // Sticky events.
   logic [1:0]    irq_mask;         // Event enables.
   logic [7:0]    aw_addr;          // Held write address.
   logic [31:0]   w_data;           // Held write data.
   logic [3:0]    w_strb;           // Held byte enables.
   logic          aw_got;           // Write address held.
   logic          w_got;            // Write data held.

   motion_if mi ();

   // -------------------------------------------------------------------
   // Decoding.
   // -------------------------------------------------------------------
   wire           ch_ok    = (phase == 2'h1) ? (SIG_B & LOCK_B)
                                             : (SIG_A & LOCK_A);
   wire           sync_err = (phase == 2'h1) ? SYNC_ERR_B : SYNC_ERR_A;
   wire           is_chan  = (phase < 2'h2);
   wire [2:0]     lslot    = lock_slot(phase);
   wire [2:0]     pslot    = path_slot(phase);
   wire [DW-1:0]  cap_lo   = mi.seen0 & ~mi.seen1;
   wire [DW-1:0]  cap_hi   = mi.seen1 & ~mi.seen0;
   wire           do_write = aw_got & w_got & ~BVALID;
   wire           wr_ctrl  = do_write && aw_addr == OFS_CTRL && w_strb[0];
   wire           wr_imask = do_write && aw_addr == OFS_IRQ_MASK
                             && w_strb[0];
   wire           wr_istat = do_write && aw_addr == OFS_IRQ_STAT
                             && w_strb[0];
   wire           wr_rlen  = do_write && aw_addr == OFS_RECLEN;
   wire           start    = wr_ctrl && w_data[CTRL_START] && !busy;
   wire           ev_done  = (state == S_DONE);
   wire           ev_fail  = ev_done && any_fail;
   wire [1:0]     ev       = {ev_fail, ev_done};
   wire [1:0]     next_irq_stat = (irq_stat & ~(wr_istat ? w_data[1:0]
                                                         : 2'h0)) | ev;
   wire           test_b   = busy && (phase == 2'h1);
   wire           test_c   = busy && (phase >= 2'h2);
   wire           route_b  = busy ? test_b : sel_b_sw;
   wire           route_c  = busy ? test_c : (mode_sw != ACQ_VIDEO);
   wire [1:0]     next_mode = !busy ? mode_sw
                            : (phase == 2'h2) ? ACQ_EYE
                            : (phase == 2'h3) ? ACQ_JITTER : ACQ_VIDEO;
   wire [15:0]    res_word;
   wire           ar_map   = (ARADDR <= OFS_RECLEN) && (ARADDR[1:0] == 2'h0);
   wire           aw_map   = (aw_addr <= OFS_RECLEN)
                             && (aw_addr[1:0] == 2'h0);
   wire [1:0]     sidx     = 2'((ARADDR - OFS_STUCK0) >> 2);
   wire           ar_stuck = (ARADDR >= OFS_STUCK0) && (ARADDR < OFS_IRQ_STAT);
   logic [31:0]   rd_mux;

   // Pack the held outcomes two bits per check.
   genvar gi;
   generate
      for (gi = 0; gi < NCHK; gi++) begin : g_res
         assign res_word[2*gi +: 2] = res[gi];
      end
   endgenerate

   // Read data selection; unmapped words read as zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (ar_stuck) begin
         rd_mux[DW-1:0]             = stuck_lo[sidx];
         rd_mux[STUCK_HI_L +: DW]   = stuck_hi[sidx];
      end else if (ARADDR == OFS_CTRL) begin
         rd_mux[CTRL_SEL_B]         = sel_b_sw;
         rd_mux[CTRL_MODE_L +: 2]   = mode_sw;
      end else if (ARADDR == OFS_STATUS) begin
         rd_mux[STAT_BUSY]          = busy;
         rd_mux[STAT_DONE]          = done;
      end else if (ARADDR == OFS_RESULT) begin
         rd_mux[15:0]               = res_word;
      end else if (ARADDR == OFS_IRQ_STAT) begin
         rd_mux[1:0]                = irq_stat;
      end else if (ARADDR == OFS_IRQ_MASK) begin
         rd_mux[1:0]                = irq_mask;
      end else if (ARADDR == OFS_RECLEN) begin
         rd_mux[15:0]               = reclen;
      end
   end

   // -------------------------------------------------------------------
   // Data path and movement checker.
   // -------------------------------------------------------------------
   // The checker watches the routed output, so the whole path is proven.
   assign mi.valid = (state == S_CAPTURE);
   assign mi.data  = VIDEO_OUT; // RULE_05
   assign mi.len   = reclen;
   assign mi.start = (state == S_ROUTE) && (settle == 4'(SETTLE_CYC));

   video_route u_route (
      .CLK    (CLK),
      .RSTN   (RSTN),
      .data_a (DATA_A),
      .data_b (DATA_B),
      .data_c (DATA_C),
      .sel_b  (route_b),
      .sel_c  (route_c), // RULE_08 RULE_09
      .video  (VIDEO_OUT)
   );

   bit_motion u_motion (
      .CLK  (CLK),
      .RSTN (RSTN),
      .mi   (mi)
   );

   // -------------------------------------------------------------------
   // Sequencer.
   // -------------------------------------------------------------------
   // One pass per phase; channel B reuses the channel A steps.
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         state    <= S_IDLE;
         phase    <= 2'h0;
         settle   <= 4'h0;
         busy     <= 1'b0;
         done     <= 1'b0;
         any_fail <= 1'b0;
         ACQ_MODE <= ACQ_VIDEO;
         for (int i = 0; i < NCHK; i++) res[i] <= OUT_NONE;
         for (int i = 0; i < NPATH; i++) begin
            stuck_lo[i] <= '0;
            stuck_hi[i] <= '0;
         end
      end else begin
         ACQ_MODE <= next_mode;
         unique case (state)
            S_IDLE: begin
               if (start) begin
                  // Fresh run: earlier outcomes are dropped here and at reset only.
                  for (int i = 0; i < NCHK; i++) res[i] <= OUT_NONE; // RULE_11
                  busy     <= 1'b1;
                  done     <= 1'b0;
                  any_fail <= 1'b0;
                  phase    <= 2'h0;
                  state    <= S_LOCK;
               end
            end
            S_LOCK: begin
               if (!ch_ok) begin
                  if (is_chan) begin
                     res[lslot]        <= OUT_NA; // RULE_02
                     res[lslot + 3'h1] <= OUT_NA; // RULE_02
                  end
                  res[pslot] <= OUT_NA; // RULE_02 RULE_08 RULE_09
                  state      <= S_NEXT;
               end else if (is_chan) begin
                  res[lslot] <= OUT_PASS; // RULE_01
                  state      <= S_SYNC;
               end else begin
                  state <= S_ROUTE;
               end
            end
            S_SYNC: begin
               if (sync_err) begin
                  res[lslot + 3'h1] <= OUT_FAIL; // RULE_03
                  res[pslot]        <= OUT_NA; // RULE_03
                  any_fail          <= 1'b1;
                  state             <= S_NEXT;
               end else begin
                  res[lslot + 3'h1] <= OUT_PASS; // RULE_04
                  state             <= S_ROUTE;
               end
            end
            S_ROUTE: begin
               // Let the new routing flush through the output register.
               settle <= settle + 4'h1;
               if (mi.start) begin
                  settle <= 4'h0;
                  state  <= S_CAPTURE;
               end
            end
            S_CAPTURE: begin
               if (mi.done) begin
                  stuck_lo[phase] <= cap_lo; // RULE_05
                  stuck_hi[phase] <= cap_hi; // RULE_05
                  if ((cap_lo | cap_hi) != '0) begin
                     res[pslot] <= OUT_FAIL; // RULE_10
                     any_fail   <= 1'b1;
                  end else begin
                     res[pslot] <= OUT_PASS;
                  end
                  state <= S_NEXT;
               end
            end
            S_NEXT: begin
               if (phase == 2'h3) begin
                  state <= S_DONE;
               end else begin
                  phase <= phase + 2'h1; // RULE_07
                  state <= S_LOCK;
               end
            end
            S_DONE: begin
               busy  <= 1'b0;
               done  <= 1'b1;
               phase <= 2'h0;
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Software controls and interrupt.
   // -------------------------------------------------------------------
   // Events win over a clear arriving in the same cycle.
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         sel_b_sw <= 1'b0;
         mode_sw  <= ACQ_VIDEO;
         reclen   <= RECLEN_RST;
         irq_mask <= 2'h0;
         irq_stat <= 2'h0;
         IRQ      <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            sel_b_sw <= w_data[CTRL_SEL_B];
            // Code 3 names no acquisition mode, so it falls back to video.
            mode_sw  <= (w_data[CTRL_MODE_L +: 2] == 2'h3) ? ACQ_VIDEO
                        : acq_t'(w_data[CTRL_MODE_L +: 2]);
         end
         if (wr_rlen && w_strb[1:0] == 2'h3) begin
            reclen <= (w_data[15:0] == 16'h0000) ? 16'h0001 : w_data[15:0];
         end
         if (wr_imask) begin
            irq_mask <= w_data[1:0];
         end
         irq_stat <= next_irq_stat;
         IRQ      <= |(next_irq_stat & irq_mask);
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite slave.
   // -------------------------------------------------------------------
   // Address and data are taken in either order; the response follows.
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         AWREADY <= 1'b1;
         WREADY  <= 1'b1;
         aw_got  <= 1'b0;
         w_got   <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         BVALID  <= 1'b0;
         BRESP   <= RESP_OK;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_addr <= AWADDR;
            aw_got  <= 1'b1;
            AWREADY <= 1'b0;
         end
         if (WVALID && WREADY) begin
            w_data <= WDATA;
            w_strb <= WSTRB;
            w_got  <= 1'b1;
            WREADY <= 1'b0;
         end
         if (do_write) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            BVALID <= 1'b1;
            BRESP  <= aw_map ? RESP_OK : RESP_SLV;
         end
         if (BVALID && BREADY) begin
            BVALID  <= 1'b0;
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
         end
      end
   end

   // One read in flight; the answer comes the cycle after the address.
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         ARREADY <= 1'b1;
         RVALID  <= 1'b0;
         RDATA   <= 32'h0000_0000;
         RRESP   <= RESP_OK;
      end else if (ARVALID && ARREADY) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b1;
         RDATA   <= rd_mux;
         RRESP   <= ar_map ? RESP_OK : RESP_SLV;
      end else if (RVALID && RREADY) begin
         RVALID  <= 1'b0;
         ARREADY <= 1'b1;
      end
   end

endmodule : serial_path_test

/* inc/selftest_pkg.sv */
// Constants, types and helpers shared by the serial video path self-test.
//
// Overview of operation
// RULE_01: Pass only with signal-present and lock high.
// RULE_02: Missing signal or lock marks channel checks N/A.
// RULE_03: Line-sync error fails; data path becomes N/A.
// RULE_04: Data path checked only without line-sync error.
// RULE_05: Route words to capture; report stuck bits.
// RULE_06: A/B mux, then second mux drives output.
// RULE_07: Channel B repeats channel A sequence identically.
// RULE_08: Eye path passes C data; needs channel A.
// RULE_09: Jitter path passes C data; needs channel A.
// RULE_10: Moving bit needs both zero and one seen.
// RULE_11: One held outcome per check until restart.
package selftest_pkg;

   // -------------------------------------------------------------------
   // Widths and enumerations.
   // -------------------------------------------------------------------
   localparam int DW = 10;                  // Deserialized word width.
   localparam int NCHK = 8;                 // Outcome slots.
   localparam int NPATH = 4;                // Data paths: A, B, eye, jitter.

   // Outcome of one check; NONE only while a run has not reached it.
   typedef enum logic [1:0] {OUT_NONE, OUT_PASS, OUT_FAIL, OUT_NA} outcome_t;

   // Acquisition mode presented to the capture side.
   typedef enum logic [1:0] {ACQ_VIDEO, ACQ_EYE, ACQ_JITTER} acq_t;

   // -------------------------------------------------------------------
   // Register byte offsets.
   // -------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_RESULT   = 8'h08;
   localparam logic [7:0] OFS_STUCK0   = 8'h0C; // Four words, A/B/eye/jit.
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
   localparam logic [7:0] OFS_RECLEN   = 8'h24;

   // -------------------------------------------------------------------
   // Field positions and reset values.
   // -------------------------------------------------------------------
   localparam int CTRL_START  = 0;          // Write one to start a run.
   localparam int CTRL_SEL_B  = 1;          // Normal routing: channel B.
   localparam int CTRL_MODE_L = 2;          // Normal acquisition mode, 2 bits.
   localparam int STAT_BUSY   = 0;
   localparam int STAT_DONE   = 1;
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_FAIL    = 1;
   localparam int STUCK_HI_L  = 16;         // Stuck-high mask position.
   localparam logic [15:0] RECLEN_RST = 16'h0400;
   localparam logic [1:0]  RESP_OK    = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;

   // -------------------------------------------------------------------
   // Timing.
   // -------------------------------------------------------------------
   localparam int CLK_NS    = 5;
   localparam int SETTLE_NS = 20;           // Route settling before capture.
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

   // Result slot of each check within the outcome array.
   function automatic logic [2:0] lock_slot(input logic [1:0] ph);
      lock_slot = (ph == 2'h1) ? 3'h3 : 3'h0;
   endfunction : lock_slot

   function automatic logic [2:0] path_slot(input logic [1:0] ph);
      unique case (ph)
         2'h0:    path_slot = 3'h2;
         2'h1:    path_slot = 3'h5;
         2'h2:    path_slot = 3'h6;
         default: path_slot = 3'h7;
      endcase
   endfunction : path_slot

endpackage : selftest_pkg

/* inc/motion_if.sv */
// Interface between the sequencer and the bit movement checker.
interface motion_if;
   import selftest_pkg::*;
   logic            start;    // One-cycle pulse, clears the record.
   logic            valid;    // Sample present this cycle.
   logic [DW-1:0]   data;     // Routed sample.
   logic [15:0]     len;      // Samples in one record.
   logic            done;     // One-cycle pulse at end of record.
   logic [DW-1:0]   seen0;    // A zero was observed on the bit.
   logic [DW-1:0]   seen1;    // A one was observed on the bit.
   modport chk (input start, valid, data, len, output done, seen0, seen1);
   modport ctl (output start, valid, data, len, input done, seen0, seen1);
endinterface : motion_if

/* core/bit_motion.sv */
// Records which levels each data bit takes over one capture record.
module bit_motion
   import selftest_pkg::*;
(
   // Clock and reset.
   input  wire logic CLK,
   input  wire logic RSTN,
   // Sequencer side.
   motion_if.chk     mi
);

   logic [15:0] count;        // Samples taken so far.
   logic        active;       // Record in progress.
   logic [DW-1:0] next_seen0; // Accumulated zero observations.
   logic [DW-1:0] next_seen1; // Accumulated one observations.
   logic        last;         // This sample closes the record.

   // A start restarts the record with no levels seen.
   assign next_seen0 = mi.start ? '0 : (mi.seen0 | ~mi.data);
   assign next_seen1 = mi.start ? '0 : (mi.seen1 | mi.data);
   assign last = active && mi.valid && (count + 16'h0001 >= mi.len);

   // Accumulate both levels per bit; moving needs both.
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         count    <= '0;
         active   <= 1'b0;
         mi.done  <= 1'b0;
         mi.seen0 <= '0;
         mi.seen1 <= '0;
      end else begin
         mi.done <= last;
         if (mi.start) begin
            count    <= '0;
            active   <= 1'b1;
            mi.seen0 <= next_seen0;
            mi.seen1 <= next_seen1;
         end else if (active && mi.valid) begin
            count    <= count + 16'h0001;
            mi.seen0 <= next_seen0; // RULE_10
            mi.seen1 <= next_seen1; // RULE_10
            if (last) begin
               active <= 1'b0;
            end
         end
      end
   end

endmodule : bit_motion

/* core/video_route.sv */
// Two-stage word multiplexer feeding the line drivers.
module video_route
   import selftest_pkg::*;
(
   // Clock and reset.
   input  wire logic          CLK,
   input  wire logic          RSTN,
   // Sources.
   input  wire logic [DW-1:0] data_a,
   input  wire logic [DW-1:0] data_b,
   input  wire logic [DW-1:0] data_c,
   // Selection.
   input  wire logic          sel_b,
   input  wire logic          sel_c,
   // Registered output toward acquisition.
   output logic [DW-1:0]      video
);

   logic [DW-1:0] chan_word; // Output of the A/B stage.
   logic [DW-1:0] out_word;  // Output of the second stage.

   // First stage picks a channel, second passes it or channel C.
   assign chan_word = sel_b ? data_b : data_a; // RULE_06
   assign out_word  = sel_c ? data_c : chan_word; // RULE_06

   // Register so the driver sees a clean word each cycle.
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         video <= '0;
      end else begin
         video <= out_word;
      end
   end

endmodule : video_route

/* test/serial_path_test_asserts.sv */
// Port-level assertions for the serial video path self-test.
module serial_path_test_asserts
   import selftest_pkg::*;
(
   // Watched ports.
   input wire logic          CLK, RSTN, AWVALID, AWREADY, WVALID, WREADY,
   input wire logic          BVALID, BREADY, ARVALID, ARREADY, RVALID,
   input wire logic          RREADY, IRQ,
   input wire logic [1:0]    ACQ_MODE,
   input wire logic [DW-1:0] VIDEO_OUT, DATA_C
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   a_reset_idle: assert property (disable iff (1'b0) !RSTN |=>
      AWREADY && WREADY && ARREADY && !BVALID && !RVALID && !IRQ)
      else $error("bus not idle after reset");
   a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read answer late");
   a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY
      |-> ##[1:2] BVALID) else $error("write answer late");
   a_b_clear: assert property (BVALID && BREADY |=> !BVALID)
      else $error("write answer stuck");
   a_r_clear: assert property (RVALID && RREADY |=> !RVALID)
      else $error("read answer stuck");
   a_ar_block: assert property (RVALID |-> !ARREADY)
      else $error("read accepted while answering");
   a_aw_block: assert property (BVALID |-> !AWREADY && !WREADY)
      else $error("write accepted while answering");
   // The C words must reach the line drivers in eye and jitter modes.
   a_route_c: assert property (
      ACQ_MODE != 2'h0 && $past(ACQ_MODE) != 2'h0 &&
      $past(ACQ_MODE, 2) != 2'h0 |-> VIDEO_OUT == $past(DATA_C))
      else $error("third channel not routed");
   a_mode_legal: assert property (ACQ_MODE != 2'h3)
      else $error("illegal acquisition mode");
   c_eye: cover property (ACQ_MODE == 2'h1);
   c_jit: cover property (ACQ_MODE == 2'h2);
   c_irq: cover property ($rose(IRQ));
endmodule : serial_path_test_asserts

bind serial_path_test serial_path_test_asserts i_chk (.*);

/* test/acq_model.sv */
// Acquisition side model: notes every acquisition mode it is handed.
module acq_model
   import selftest_pkg::*;
(
   // Routed stream.
   input  wire logic          CLK,
   input  wire logic [1:0]    ACQ_MODE,
   input  wire logic [DW-1:0] VIDEO_OUT,
   // Modes seen, one bit each.
   output logic [2:0]         modes
);
   initial modes = 3'h0;
   // Words are not sampled; only the mode, which decides how they would be stored, is noted.
   always @(posedge CLK) if (ACQ_MODE < 2'h3) modes[ACQ_MODE] <= 1'b1;
endmodule : acq_model

/* test/test_serial_path_test.sv */
// Self-checking bench for the serial video path self-test.
module test_serial_path_test
   import selftest_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLK, RSTN, SIG_A, LOCK_A, SIG_B, LOCK_B, SYNC_ERR_A, SYNC_ERR_B;
   logic AWVALID, WVALID, BREADY, ARVALID, RREADY, tg;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
   logic [DW-1:0] DATA_A, DATA_B, DATA_C, VIDEO_OUT, c_hi, c_lo;
   logic [7:0]    AWADDR, ARADDR;
   logic [31:0]   WDATA, RDATA, seed, rdat;
   logic [3:0]    WSTRB;
   logic [1:0]    BRESP, RRESP, ACQ_MODE;
   logic [2:0]    modes;
   logic [34:0]   note;
   logic [34:0]   notes[$];  // Check flag, response, data.
   int            error_cnt = 0;
   int            compares = 0;
   serial_path_test i_dut (.*);
   acq_model i_acq (.*);
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      xs = x ^ (x << 5);
   endfunction : xs
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   // Each word is followed by its inverse, so every free bit moves
   // within any three samples of a record.
   always @(posedge CLK) begin
      if (tg) seed <= xs(seed);
      tg <= ~tg;
      DATA_A <= seed[9:0] ^ {DW{tg}};
      DATA_B <= seed[19:10] ^ {DW{tg}};
      DATA_C <= (seed[29:20] ^ {DW{tg}}) & ~c_lo | c_hi;
   end
   task automatic chk(input string nm, input logic [33:0] e,
                      input logic [33:0] s);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task automatic close_out();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      AWADDR <= a;
      WDATA <= d;
      {AWVALID, WVALID} <= 2'h3;
      do begin
         @(posedge CLK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
      end while (!BVALID);
      chk("bresp", 34'(r), 34'(BRESP));
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [34:0] e);
      notes.push_back(e);
      ARADDR <= a;
      ARVALID <= 1'b1;
      do begin
         @(posedge CLK);
         if (ARREADY) ARVALID <= 1'b0;
         rdat = RDATA;
      end while (!RVALID);
   endtask : rd
   // Read answers are judged against the oldest note.
   always @(posedge CLK) begin
      if (RVALID && RREADY) begin
         note = notes.pop_front();
         if (note[34]) chk("read", note[33:0], {RRESP, RDATA});
      end
   end
   task automatic run(input string nm, input logic [15:0] res);
      wr(OFS_CTRL, 32'h1, RESP_OK);
      rdat = 32'h1;
      for (int i = 0; i < 300 && rdat[1:0] != 2'h2; i++) rd(OFS_STATUS, '0);
      chk("done", 34'h2, 34'(rdat[1:0]));
      rd(OFS_RESULT, {1'b1, RESP_OK, 16'h0, res});
      $display("test %s ended", nm);
   endtask : run
   initial begin
      {RSTN, AWVALID, WVALID, ARVALID, SYNC_ERR_A, SYNC_ERR_B, tg} = '0;
      {c_hi, c_lo, AWADDR, ARADDR, WDATA, DATA_A, DATA_B, DATA_C} = '0;
      {SIG_A, LOCK_A, SIG_B, LOCK_B, BREADY, RREADY} = 6'h3F;
      {WSTRB, seed, rdat} = {4'hF, 32'hA833, 32'h0};
      repeat (5) @(posedge CLK);
      RSTN <= 1'b1;
      rd(OFS_RECLEN, {1'b1, RESP_OK, 16'h0, RECLEN_RST});
      wr(OFS_RECLEN, 32'h8, RESP_OK);
      wr(8'h28, 32'h0, RESP_SLV);
      rd(8'h28, {1'b1, RESP_SLV, 32'h0});
      wr(OFS_IRQ_MASK, 32'h3, RESP_OK);
      run("all good", 16'h5555);
      chk("irq", 34'h1, 34'(IRQ));
      chk("modes", 34'h7, 34'(modes));
      wr(OFS_IRQ_STAT, 32'h3, RESP_OK);
      repeat (2) @(posedge CLK);
      chk("irq clear", 34'h0, 34'(IRQ));
      wr(OFS_IRQ_MASK, 32'h0, RESP_OK);
      SYNC_ERR_B <= 1'b1;
      run("sync err B", 16'h5E55);
      rd(OFS_IRQ_STAT, {1'b1, RESP_OK, 32'h3});
      chk("irq masked", 34'h0, 34'(IRQ));
      SYNC_ERR_B <= 1'b0;
      SIG_A <= 1'b0;
      run("no signal A", 16'hF57F);
      SIG_A <= 1'b1;
      LOCK_B <= 1'b0;
      run("no lock B", 16'h5FD5);
      LOCK_B <= 1'b1;
      {c_hi, c_lo} <= {10'h008, 10'h001};
      run("stuck C", 16'hA555);
      rd(OFS_STUCK0 + 8'h08, {1'b1, RESP_OK, 32'h0008_0001});
      wr(OFS_CTRL, 32'h6, RESP_OK);
      rd(OFS_CTRL, {1'b1, RESP_OK, 32'h6});
      chk("acq mode", 34'h1, 34'(ACQ_MODE));
      $display("test normal routing ended");
      close_out();
   end
   // About 350 cycles are needed; 20000 leaves a wide margin.
   initial begin
      #100000;
      error_cnt++;
      close_out();
   end
endmodule : test_serial_path_test
